// File: design/dsw_top.sv
`timescale 1ns/10ps
// Operation
// - A written timeout value starts the timer counting down to zero.
// - Expiry without restart forces a whole-system reset.
// - A fresh value restarts either countdown; keyboard activity restarts only the first, if enabled.
// - Two separate timers exist, at different ports, either usable.
// - The first timer ticks per second or per minute, set by control regs.
// - The first timer takes 0 to 15300 seconds and zero disables it.
// - The second timer loads at one I/O port and disables at another.
// - The second timer counts a 1 Hz tick, one second per count.
// - The second timer's counter is eight bits, one-second steps.
// - Load zero means no timeout, N means N seconds, FF gives 255 s.
// - Disable then re-enable refreshes the second timer.
// - Any data written to the disable port stops the second timer.
module dsw_top #(
  parameter int CYC_PER_TICK = dsw_pkg::CYC_PER_TICK
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // I/O port access
  input  wire dsw_pkg::dsw_io_req_s io_req,
  output logic [7:0]               io_rdata,
  // Keyboard activity pin
  input  wire logic                kbd_activity,
  // System reset request
  output logic                     sys_reset_out
);

  localparam int PW = $clog2(dsw_pkg::RST_PULSE_CYC + 1);
  localparam logic [PW-1:0] PULSE_LAST = PW'(dsw_pkg::RST_PULSE_CYC - 1);
  localparam logic [5:0] MIN_LAST = 6'(dsw_pkg::SEC_PER_MIN - 1);

  logic sec_tick;

  dsw_tick #(
    .CYC_PER_TICK (CYC_PER_TICK)
  ) u_tick (
    .clk    (clk),
    .resetn (resetn),
    .tick   (sec_tick)
  );

  function automatic logic is_wr(input dsw_pkg::dsw_io_req_s r,
                                 input logic [15:0] a);
    is_wr = r.wr && (r.addr == a);
  endfunction

  // Keyboard synchroniser and edge detect
  logic kbd_s1_reg;
  logic kbd_s2_reg;
  logic kbd_s3_reg;
  logic kbd_evt;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      kbd_s1_reg <= 1'b0;
      kbd_s2_reg <= 1'b0;
      kbd_s3_reg <= 1'b0;
    end
    else
    begin
      kbd_s1_reg <= kbd_activity;
      kbd_s2_reg <= kbd_s1_reg;
      kbd_s3_reg <= kbd_s2_reg;
    end
  end

  assign kbd_evt = kbd_s2_reg && !kbd_s3_reg;

  // Timer state
  dsw_pkg::dsw_state_e state_reg;
  dsw_pkg::dsw_state_e state_next;
  logic [PW-1:0] pulse_reg;
  logic [PW-1:0] pulse_next;
  logic [7:0]    index_reg;
  logic [7:0]    index_next;
  logic [7:0]    t1_load_reg;
  logic [7:0]    t1_load_next;
  logic [7:0]    t1_cnt_reg;
  logic [7:0]    t1_cnt_next;
  logic [5:0]    t1_sub_reg;
  logic [5:0]    t1_sub_next;
  logic          t1_en_reg;
  logic          t1_en_next;
  logic [7:0]    ctrl_a_reg;
  logic [7:0]    ctrl_a_next;
  logic [7:0]    ctrl_b_reg;
  logic [7:0]    ctrl_b_next;
  logic [7:0]    t2_cnt_reg;
  logic [7:0]    t2_cnt_next;
  logic          t2_en_reg;
  logic          t2_en_next;
  logic [7:0]    rdata_reg;
  logic [7:0]    rdata_next;

  logic wr_cfg_data;
  logic t1_minute;
  logic t1_kbd_ena;
  logic t1_step;
  logic t1_expire;
  logic t2_expire;

  assign wr_cfg_data = is_wr(io_req, dsw_pkg::ADDR_CFG_DATA);
  assign t1_minute   = ctrl_b_reg[dsw_pkg::CTRLB_MIN_BIT];
  assign t1_kbd_ena  = ctrl_a_reg[dsw_pkg::CTRLA_KBD_BIT];
  assign t1_step     = sec_tick && (!t1_minute || t1_sub_reg == MIN_LAST);
  assign t1_expire   = t1_en_reg && t1_step && t1_cnt_reg == 8'h01;
  assign t2_expire   = t2_en_reg && sec_tick && t2_cnt_reg == 8'h01;

  always_comb
  begin
    state_next   = state_reg;
    pulse_next   = pulse_reg;
    index_next   = index_reg;
    t1_load_next = t1_load_reg;
    t1_cnt_next  = t1_cnt_reg;
    t1_sub_next  = t1_sub_reg;
    t1_en_next   = t1_en_reg;
    ctrl_a_next  = ctrl_a_reg;
    ctrl_b_next  = ctrl_b_reg;
    t2_cnt_next  = t2_cnt_reg;
    t2_en_next   = t2_en_reg;
    unique case (state_reg)
      dsw_pkg::DSW_RUN:
      begin
        // First timer countdown
        if (t1_en_reg && sec_tick)
        begin
          t1_sub_next = t1_step ? 6'h00 : t1_sub_reg + 6'h01;
          if (t1_step)
            t1_cnt_next = t1_cnt_reg - 8'h01;
        end
        if (t1_en_reg && t1_kbd_ena && kbd_evt)
        begin
          t1_cnt_next = t1_load_reg;
          t1_sub_next = 6'h00;
        end
        // Second timer countdown
        if (t2_en_reg && sec_tick)
          t2_cnt_next = t2_cnt_reg - 8'h01;
        // Port writes
        if (is_wr(io_req, dsw_pkg::ADDR_CFG_IDX))
          index_next = io_req.wdata;
        if (wr_cfg_data && index_reg == dsw_pkg::IDX_COUNT)
        begin
          t1_load_next = io_req.wdata;
          t1_cnt_next  = io_req.wdata;
          t1_sub_next  = 6'h00;
          t1_en_next   = io_req.wdata != 8'h00;
        end
        if (wr_cfg_data && index_reg == dsw_pkg::IDX_CTRL_A)
          ctrl_a_next = io_req.wdata;
        if (wr_cfg_data && index_reg == dsw_pkg::IDX_CTRL_B)
          ctrl_b_next = io_req.wdata;
        if (is_wr(io_req, dsw_pkg::ADDR_T2_LOAD))
        begin
          t2_cnt_next = io_req.wdata;
          t2_en_next  = io_req.wdata != 8'h00;
        end
        if (is_wr(io_req, dsw_pkg::ADDR_T2_DIS))
          t2_en_next = 1'b0;
        // Expiry of either timer
        if (t1_expire || t2_expire)
        begin
          state_next  = dsw_pkg::DSW_PULSE;
          pulse_next  = '0;
          t1_en_next  = 1'b0;
          t2_en_next  = 1'b0;
          ctrl_a_next = dsw_pkg::RST_CTRL_A;
          ctrl_b_next = dsw_pkg::RST_CTRL_B;
        end
      end
      dsw_pkg::DSW_PULSE:
      begin
        pulse_next = pulse_reg + PW'(1);
        if (pulse_reg == PULSE_LAST)
          state_next = dsw_pkg::DSW_RUN;
      end
    endcase
  end

  // Read back
  always_comb
  begin
    rdata_next = 8'h00;
    if (io_req.rd && io_req.addr == dsw_pkg::ADDR_CFG_IDX)
      rdata_next = index_reg;
    if (io_req.rd && io_req.addr == dsw_pkg::ADDR_CFG_DATA)
    begin
      unique case (index_reg)
        dsw_pkg::IDX_COUNT:  rdata_next = t1_cnt_reg;
        dsw_pkg::IDX_CTRL_A: rdata_next = ctrl_a_reg;
        dsw_pkg::IDX_CTRL_B: rdata_next = ctrl_b_reg;
        default:             rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg   <= dsw_pkg::DSW_RUN;
      pulse_reg   <= '0;
      index_reg   <= dsw_pkg::RST_INDEX;
      t1_load_reg <= dsw_pkg::RST_COUNT;
      t1_cnt_reg  <= dsw_pkg::RST_COUNT;
      t1_sub_reg  <= 6'h00;
      t1_en_reg   <= 1'b0;
      ctrl_a_reg  <= dsw_pkg::RST_CTRL_A;
      ctrl_b_reg  <= dsw_pkg::RST_CTRL_B;
      t2_cnt_reg  <= dsw_pkg::RST_COUNT;
      t2_en_reg   <= 1'b0;
      rdata_reg   <= 8'h00;
    end
    else
    begin
      state_reg   <= state_next;
      pulse_reg   <= pulse_next;
      index_reg   <= index_next;
      t1_load_reg <= t1_load_next;
      t1_cnt_reg  <= t1_cnt_next;
      t1_sub_reg  <= t1_sub_next;
      t1_en_reg   <= t1_en_next;
      ctrl_a_reg  <= ctrl_a_next;
      ctrl_b_reg  <= ctrl_b_next;
      t2_cnt_reg  <= t2_cnt_next;
      t2_en_reg   <= t2_en_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign sys_reset_out = (state_reg == dsw_pkg::DSW_PULSE);
  assign io_rdata      = rdata_reg;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_pulse_16;
    sys_reset_out [*8] ##1 sys_reset_out [*8] ##1 !sys_reset_out;
  endsequence

  sequence s_t2_load_nz;
    state_reg == dsw_pkg::DSW_RUN && !t1_expire && !t2_expire &&
    is_wr(io_req, dsw_pkg::ADDR_T2_LOAD) && io_req.wdata != 8'h00 &&
    !is_wr(io_req, dsw_pkg::ADDR_T2_DIS);
  endsequence

  a_pulse_length: assert property (
    $rose(sys_reset_out) |-> s_pulse_16)
    else $error("reset pulse length wrong");

  a_t2_load_start: assert property (
    s_t2_load_nz |=> t2_en_reg && t2_cnt_reg == $past(io_req.wdata))
    else $error("second timer load not taken");

  a_t2_disable_any: assert property (
    is_wr(io_req, dsw_pkg::ADDR_T2_DIS) |=> !t2_en_reg)
    else $error("disable port did not stop timer");

  a_t2_zero_none: assert property (
    is_wr(io_req, dsw_pkg::ADDR_T2_LOAD) && io_req.wdata == 8'h00
    |=> !t2_en_reg)
    else $error("zero load left timer running");

  a_t1_zero_off: assert property (
    wr_cfg_data && index_reg == dsw_pkg::IDX_COUNT &&
    io_req.wdata == 8'h00 |=> !t1_en_reg)
    else $error("zero count left first timer on");

  a_t2_expiry_reset: assert property (
    state_reg == dsw_pkg::DSW_RUN && t2_expire |=> sys_reset_out)
    else $error("expiry did not reset system");

  a_t1_count_down: assert property (
    state_reg == dsw_pkg::DSW_RUN && t1_en_reg && sec_tick &&
    !t1_minute && t1_cnt_reg > 8'h01 && !wr_cfg_data &&
    !(t1_kbd_ena && kbd_evt) && !t2_expire
    |=> t1_cnt_reg == $past(t1_cnt_reg) - 8'h01)
    else $error("first timer did not decrement");

  a_kbd_restart: assert property (
    state_reg == dsw_pkg::DSW_RUN && t1_en_reg && t1_kbd_ena &&
    kbd_evt && !wr_cfg_data && !t1_expire && !t2_expire
    |=> t1_cnt_reg == t1_load_reg && t1_sub_reg == 6'h00)
    else $error("keyboard did not restart timer");

  a_off_after_reset: assert property (
    $fell(sys_reset_out) |-> !t1_en_reg && !t2_en_reg)
    else $error("timer enabled after reset pulse");

endmodule

// File: inc/dsw_pkg.sv
package dsw_pkg;

  // I/O port map
  localparam logic [15:0] ADDR_T2_LOAD  = 16'h0440;
  localparam logic [15:0] ADDR_T2_DIS   = 16'h0443;
  localparam logic [15:0] ADDR_CFG_IDX  = 16'h03F0;
  localparam logic [15:0] ADDR_CFG_DATA = 16'h03F1;

  // Configuration register indices
  localparam logic [7:0] IDX_COUNT  = 8'hF2;
  localparam logic [7:0] IDX_CTRL_A = 8'hF3;
  localparam logic [7:0] IDX_CTRL_B = 8'hF4;

  // Field positions
  localparam int CTRLA_KBD_BIT = 2;
  localparam int CTRLB_MIN_BIT = 3;

  // Reset values
  localparam logic [7:0] RST_COUNT  = 8'h00;
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_INDEX  = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_HZ        = 250_000_000;
  localparam int TICK_S        = 1;
  localparam int CYC_PER_TICK  = CLK_HZ * TICK_S;
  localparam int SEC_PER_MIN   = 60;
  localparam int T1_MAX_SEC    = 15300;
  localparam int RST_PULSE_NS  = 64;
  localparam int RST_PULSE_CYC =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // I/O access
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } dsw_io_req_s;

  typedef enum logic {
    DSW_RUN,
    DSW_PULSE
  } dsw_state_e;

endpackage

// File: design/dsw_tick.sv
`timescale 1ns/10ps
module dsw_tick #(
  parameter int CYC_PER_TICK = dsw_pkg::CYC_PER_TICK
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Tick
  output logic      tick
);

  localparam int CW = $clog2(CYC_PER_TICK + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC_PER_TICK - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          tick_reg;
  logic          tick_next;

  // Divide clock down to 1 Hz
  always_comb
  begin
    tick_next = 1'b0;
    cnt_next  = cnt_reg + CW'(1);
    if (cnt_reg == LAST)
    begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

// File: bench/test_dsw_top.sv
`timescale 1ns/10ps
module test_dsw_top;
  localparam int          CPT = 10;
  localparam int          PW  = dsw_pkg::RST_PULSE_CYC;
  localparam logic [15:0] LD  = dsw_pkg::ADDR_T2_LOAD;
  localparam logic [15:0] DIS = dsw_pkg::ADDR_T2_DIS;
  localparam logic [15:0] IDX = dsw_pkg::ADDR_CFG_IDX;
  localparam logic [15:0] DAT = dsw_pkg::ADDR_CFG_DATA;

  logic                 clk;
  logic                 resetn;
  dsw_pkg::dsw_io_req_s io_req;
  logic [7:0]           io_rdata;
  logic                 kbd_activity;
  logic                 sys_reset_out;
  logic                 rd_d;
  logic [7:0]           exp_q[$];
  logic [7:0]           exp_v;
  int                   err_total;
  int                   tests_run;
  int                   cyc;
  int                   n;
  int                   i;

  dsw_top #(.CYC_PER_TICK(CPT)) i_dut (
    .clk           (clk),
    .resetn        (resetn),
    .io_req        (io_req),
    .io_rdata      (io_rdata),
    .kbd_activity  (kbd_activity),
    .sys_reset_out (sys_reset_out)
  );

  initial clk = 1'b0;
  always #2 clk = ~clk;

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Read results checked against the oldest note
  always @(posedge clk)
  begin
    if (rd_d === 1'b1)
    begin
      exp_v = exp_q.pop_front();
      chk(io_rdata === exp_v, "read data");
    end
    rd_d <= io_req.rd;
    cyc <= cyc + 1;
    if (cyc > 30000)
    begin
      chk(1'b0, "timeout");
      end_sim();
    end
  end

  task automatic wr_io(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    io_req.wr <= 1'b0;
  endtask

  task automatic rd_io(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    io_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    io_req.rd <= 1'b0;
  endtask

  task automatic cfg(input logic [7:0] x, input logic [7:0] v);
    wr_io(IDX, x);
    wr_io(DAT, v);
  endtask

  // Expiry inside a cycle window, then pulse width
  task automatic wait_rst(input int lo, input int hi);
    int c;
    int w;
    c = 0;
    w = 0;
    while (sys_reset_out !== 1'b1 && c < hi + 2)
    begin
      @(posedge clk);
      #1;
      c++;
    end
    chk(c >= lo && c <= hi, "expiry time");
    while (sys_reset_out === 1'b1 && w < 4 * PW)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    chk(w == PW, "reset pulse width");
  endtask

  task automatic quiet(input int cnt);
    logic seen;
    seen = 1'b0;
    repeat (cnt)
    begin
      @(posedge clk);
      #1;
      if (sys_reset_out !== 1'b0)
        seen = 1'b1;
    end
    chk(seen === 1'b0, "unexpected reset");
  endtask

  task automatic kbd_pulse();
    @(posedge clk);
    kbd_activity <= 1'b1;
    repeat (3) @(posedge clk);
    kbd_activity <= 1'b0;
  endtask

  initial
  begin
    io_req = '0;
    kbd_activity = 1'b0;
    resetn = 1'b0;
    rd_d = 1'b0;
    cyc = 0;
    err_total = 0;
    tests_run = 0;
    void'($urandom(32'he91a));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    // Second timer: smallest, random and largest loads
    for (i = 0; i < 3; i++)
    begin
      n = (i == 0) ? 1 : (i == 1) ? 2 + $urandom % 8 : 255;
      wr_io(LD, 8'(n));
      wait_rst((n - 1) * CPT, n * CPT + 3);
    end
    quiet(30 * CPT);
    $display("Test second_expiry done");
    // Zero load, disable with random data, unmapped accesses
    wr_io(LD, 8'h00);
    quiet(30 * CPT);
    wr_io(LD, 8'h03);
    wr_io(DIS, 8'($urandom));
    wr_io(16'h0441, 8'h02);
    rd_io(LD, 8'h00);
    rd_io(16'h0500, 8'h00);
    quiet(30 * CPT);
    $display("Test second_disable done");
    // Refresh by disable then re-enable
    wr_io(LD, 8'h03);
    for (i = 0; i < 6; i++)
    begin
      quiet(CPT);
      wr_io(DIS, 8'($urandom));
      wr_io(LD, 8'h03);
    end
    wait_rst(2 * CPT, 3 * CPT + 3);
    $display("Test second_refresh done");
    // First timer in seconds mode, control readback
    cfg(dsw_pkg::IDX_CTRL_B, 8'h00);
    cfg(dsw_pkg::IDX_CTRL_A, 8'h04);
    rd_io(DAT, 8'h04);
    n = 2 + $urandom % 8;
    cfg(dsw_pkg::IDX_COUNT, 8'(n));
    wait_rst((n - 1) * CPT, n * CPT + 3);
    wr_io(IDX, dsw_pkg::IDX_CTRL_A);
    rd_io(IDX, dsw_pkg::IDX_CTRL_A);
    rd_io(DAT, 8'h00);
    $display("Test first_seconds done");
    // Keyboard activity restarts the first timer
    cfg(dsw_pkg::IDX_CTRL_A, 8'h04);
    cfg(dsw_pkg::IDX_COUNT, 8'h03);
    for (i = 0; i < 6; i++)
    begin
      quiet(CPT);
      kbd_pulse();
    end
    wait_rst(2 * CPT - 4, 3 * CPT + 6);
    $display("Test first_keyboard done");
    // Zero disables the first timer
    cfg(dsw_pkg::IDX_COUNT, 8'h03);
    cfg(dsw_pkg::IDX_COUNT, 8'h00);
    rd_io(DAT, 8'h00);
    quiet(60 * CPT);
    $display("Test first_zero done");
    // Minute mode
    cfg(dsw_pkg::IDX_CTRL_B, 8'h08);
    rd_io(DAT, 8'h08);
    cfg(dsw_pkg::IDX_COUNT, 8'h02);
    rd_io(DAT, 8'h02);
    wait_rst(60 * CPT, 120 * CPT + 3);
    rd_io(DAT, 8'h00);
    repeat (3) @(posedge clk);
    chk(exp_q.size() == 0, "reads left unchecked");
    $display("Test first_minutes done");
    end_sim();
  end
endmodule
